// ===== acsp_defines.svh
// constants of the serial configuration port: offsets, fields, resets, timing
// assumes inclusion by bare name from every design file that needs them
`ifndef ACSP_DEFINES_SVH
`define ACSP_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////
// register map
`define ACSP_ADDR_PORT_CFG 8'h00
`define ACSP_ADDR_CHIP_LAST 8'h02
`define ACSP_ADDR_FUNC_FIRST 8'h08
`define ACSP_ADDR_FUNC_LAST 8'hA8
`define ACSP_ADDR_OUT_FMT 8'h14
`define ACSP_ADDR_XFER 8'hFF
`define ACSP_OUT_FMT_RST 8'h01
`define ACSP_PORT_CFG_RST 8'h00
`define ACSP_XFER_CMD 8'h01
`define ACSP_PORT_CFG_LSB_BIT 6

////////////////////////////////////////////////////////////////////////////
// shadowed locations: seven single ones, then a run from 0x3A to 0x4C
`define ACSP_SHADOW_N 26
`define ACSP_SHADOW_FIXED 7
`define ACSP_SHADOW_RUN_FIRST 8'h3A
`define ACSP_SHADOW_OUT_FMT_IDX 4

////////////////////////////////////////////////////////////////////////////
// instruction layout
`define ACSP_INSTR_LAST_BIT 4'hF
`define ACSP_BYTE_LAST_BIT 3'h7
`define ACSP_RW_BIT 14
`define ACSP_WLEN_HI_BIT 13
`define ACSP_WLEN_LO_BIT 12
`define ACSP_WLEN_STREAM 2'h3

////////////////////////////////////////////////////////////////////////////
// timing: select held high this long counts as tied high
`define ACSP_TIED_HIGH_NS 1000
`define ACSP_CORE_PERIOD_NS 50
`define ACSP_TIED_HIGH_CYC ((`ACSP_TIED_HIGH_NS + `ACSP_CORE_PERIOD_NS - 1) / `ACSP_CORE_PERIOD_NS)

`endif

// ===== acsp_pkg.sv
// types shared by the serial configuration port files
// assumes nothing beyond a SystemVerilog compiler
package acsp_pkg;

  typedef enum logic [0:0] {
    ACSP_PH_INSTR = 1'b0,
    ACSP_PH_DATA = 1'b1
  } acsp_phase_e;

  typedef logic [7:0] acsp_byte_t;

endpackage

// ===== acsp_sync.sv
// two-stage level synchroniser, one per bit
// assumes its inputs are levels that hold for several destination cycles
module acsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // first stage feeds the second stage and nothing else
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// ===== acsp_hold_det.sv
// flags a synchronised level that has stayed high for a fixed time
// assumes i_level is already synchronous to i_clk
`include "acsp_defines.svh"

module acsp_hold_det (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_level,
  output logic o_held
);

  localparam logic [7:0] HOLD_CYC = 8'(`ACSP_TIED_HIGH_CYC);

  logic [7:0] cnt;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 8'h00;
    end else if (!i_level) begin
      cnt <= 8'h00;
    end else if (cnt != HOLD_CYC) begin
      cnt <= cnt + 8'h01;
    end
  end

  // a short pause between bytes must not hand the pins to other functions
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_held <= 1'b0;
    end else begin
      o_held <= i_level && (cnt == HOLD_CYC);
    end
  end

endmodule

// ===== acsp_port.sv
// serial configuration port: three-wire link, byte register map, shadowing
// assumes the host moves select and data only around its own serial clock,
// so both are sampled directly on that clock; the core clock is unrelated
`include "acsp_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Operation
// - port uses serial clock, one shared data line and active-low select
// - a frame starts at the first rising clock after select falls
// - in a streaming frame (word-length bits 3) select held low keeps streaming data words without end
// - select may rise between bytes; a counted frame resumes where it paused, a streaming frame ends
// - select tied high floats the data pin and enables secondary functions
// - every frame opens with a sixteen-bit instruction from the host
// - two word-length bits of the instruction set the data word count
// - all data after the instruction moves in eight-bit words
// - first instruction bit chooses read or write and the line direction
// - on read the device drives the data line after the instruction
// - most significant bit first after reset; a config bit selects LSB first (code applies it to data words only; instructions stay MSB first)
// - serial clock and select are only ever inputs to the device
// - map holds chip config 0x00-0x02, functions 0x08-0xA8, transfer 0xFF
// - output format register at 0x14 resets to 0x01, twos complement
// - reset loads the critical registers with their default values
// - shadowed addresses change nothing until a transfer is issued
// - writing 0x01 to 0xFF copies all shadows at once, then self-clears
module acsp_port (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_sel_n,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_alt_func_en,
  output logic [7:0] o_output_format,
  output logic [`ACSP_SHADOW_N*8-1:0] o_active_cfg,
  output logic o_shadow_update
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] shadow_addr(input int idx);
    logic [7:0] a;
    a = 8'h00;
    case (idx)
      0: a = 8'h09;
      1: a = 8'h0B;
      2: a = 8'h0D;
      3: a = 8'h10;
      4: a = `ACSP_ADDR_OUT_FMT;
      5: a = 8'h18;
      6: a = 8'h21;
      default: a = `ACSP_SHADOW_RUN_FIRST + 8'(idx - `ACSP_SHADOW_FIXED);
    endcase
    return a;
  endfunction

  function automatic logic [7:0] reset_val(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `ACSP_ADDR_OUT_FMT) begin
      v = `ACSP_OUT_FMT_RST;
    end else if (a == `ACSP_ADDR_PORT_CFG) begin
      v = `ACSP_PORT_CFG_RST;
    end
    return v;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a <= `ACSP_ADDR_CHIP_LAST) ||
           ((a >= `ACSP_ADDR_FUNC_FIRST) && (a <= `ACSP_ADDR_FUNC_LAST));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: frame tracking on the serial clock

  acsp_pkg::acsp_phase_e phase;
  logic [3:0] bit_cnt;
  logic [14:0] instr;
  logic rd_frame;
  logic stream;
  logic [1:0] words_left;
  logic [7:0] addr;
  logic [6:0] dshift;
  logic desel_tgl;
  logic desel_seen;
  logic xfer_tgl;
  logic [7:0] regs [0:255];
  logic lsb_first;
  logic restart;
  logic byte_end;
  logic [7:0] in_byte;
  logic wr_en;
  logic [7:0] rdata;
  logic [`ACSP_SHADOW_N*8-1:0] shadow_vec;

  // select only gates and frames; it is never driven back
  always_ff @(posedge i_sel_n or posedge i_rst) begin
    if (i_rst) begin
      desel_tgl <= 1'b0;
    end else begin
      desel_tgl <= ~desel_tgl;
    end
  end

  assign lsb_first = regs[`ACSP_ADDR_PORT_CFG][`ACSP_PORT_CFG_LSB_BIT];
  // a streaming frame closes when select rises; counted frames only pause
  assign restart = (desel_tgl != desel_seen) && stream;
  assign byte_end = (phase == acsp_pkg::ACSP_PH_DATA) &&
                    (bit_cnt[2:0] == `ACSP_BYTE_LAST_BIT);
  assign in_byte = lsb_first ? {i_sdio, dshift} :
                               {dshift, i_sdio};
  assign wr_en = !i_sel_n && !restart && byte_end && !rd_frame;

  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      desel_seen <= 1'b0;
    end else if (!i_sel_n) begin
      desel_seen <= desel_tgl;
    end
  end

  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      phase <= acsp_pkg::ACSP_PH_INSTR;
      bit_cnt <= 4'h0;
      instr <= 15'h0000;
      rd_frame <= 1'b0;
      stream <= 1'b0;
      words_left <= 2'h0;
      addr <= 8'h00;
    end else if (!i_sel_n) begin
      if (restart) begin
        // this edge carries the first instruction bit of a new frame
        phase <= acsp_pkg::ACSP_PH_INSTR;
        bit_cnt <= 4'h1;
        instr <= {14'h0000, i_sdio};
        stream <= 1'b0;
        rd_frame <= 1'b0;
      end else begin
        case (phase)
          acsp_pkg::ACSP_PH_INSTR: begin
            instr <= {instr[13:0], i_sdio};
            if (bit_cnt == `ACSP_INSTR_LAST_BIT) begin
              phase <= acsp_pkg::ACSP_PH_DATA;
              bit_cnt <= 4'h0;
              rd_frame <= instr[`ACSP_RW_BIT];
              words_left <= {instr[`ACSP_WLEN_HI_BIT],
                             instr[`ACSP_WLEN_LO_BIT]};
              stream <= {instr[`ACSP_WLEN_HI_BIT],
                         instr[`ACSP_WLEN_LO_BIT]} == `ACSP_WLEN_STREAM;
              addr <= {instr[6:0], i_sdio};
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          acsp_pkg::ACSP_PH_DATA: begin
            if (byte_end) begin
              bit_cnt <= 4'h0;
              addr <= addr + 8'h01;
              if (stream) begin
                words_left <= words_left;
              end else if (words_left == 2'h0) begin
                phase <= acsp_pkg::ACSP_PH_INSTR;
                rd_frame <= 1'b0;
              end else begin
                words_left <= words_left - 2'h1;
              end
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          default: begin
            phase <= acsp_pkg::ACSP_PH_INSTR;
            bit_cnt <= 4'h0;
          end
        endcase
      end
    end
  end

  // write data assembly; the eighth bit comes straight from the pin
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      dshift <= 7'h00;
    end else if (!i_sel_n && phase == acsp_pkg::ACSP_PH_DATA) begin
      dshift <= lsb_first ? {i_sdio, dshift[6:1]} :
                            {dshift[5:0], i_sdio};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage: shadowed bytes live here until a transfer

  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 256; i++) begin
        regs[i] <= reset_val(8'(i));
      end
    end else if (wr_en && addr_mapped(addr)) begin
      regs[addr] <= in_byte;
    end
  end

  // the transfer bit is never stored, so it reads back as already cleared
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      xfer_tgl <= 1'b0;
    end else if (wr_en && addr == `ACSP_ADDR_XFER &&
                 in_byte == `ACSP_XFER_CMD) begin
      xfer_tgl <= ~xfer_tgl;
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (addr_mapped(addr)) begin
      rdata = regs[addr];
    end
  end

  always_comb begin
    shadow_vec = '0;
    for (int i = 0; i < `ACSP_SHADOW_N; i++) begin
      shadow_vec[i*8 +: 8] = regs[shadow_addr(i)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback driver on the falling edge

  // select high floats the pin at once, even with the clock stopped
  always_ff @(negedge i_sclk or posedge i_rst or posedge i_sel_n) begin
    if (i_rst || i_sel_n) begin
      o_sdio_oe <= 1'b0;
    end else begin
      o_sdio_oe <= (phase == acsp_pkg::ACSP_PH_DATA) && rd_frame;
    end
  end

  always_ff @(negedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      o_sdio <= 1'b0;
    end else if (lsb_first) begin
      o_sdio <= rdata[bit_cnt[2:0]];
    end else begin
      o_sdio <= rdata[3'h7 - bit_cnt[2:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain: transfer into active use, select watch

  logic [1:0] core_sync;
  logic xfer_seen;
  logic tied_high;
  logic xfer_req;

  acsp_sync #(
    .WIDTH(2),
    .RST_VAL(2'b10)
  ) u_sync (
    .i_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_sel_n, xfer_tgl}),
    .o_sync(core_sync)
  );

  acsp_hold_det u_hold (
    .i_clk(i_core_clk),
    .i_rst(i_rst),
    .i_level(core_sync[1]),
    .o_held(tied_high)
  );

  assign xfer_req = core_sync[0] != xfer_seen;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      xfer_seen <= 1'b0;
      o_shadow_update <= 1'b0;
    end else begin
      xfer_seen <= core_sync[0];
      o_shadow_update <= xfer_req;
    end
  end

  // shadows are quasi-static once the transfer toggle has crossed, so the
  // whole set is taken in one core edge; writes racing a transfer are lost
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `ACSP_SHADOW_N; i++) begin
        o_active_cfg[i*8 +: 8] <= reset_val(shadow_addr(i));
      end
    end else if (xfer_req) begin
      o_active_cfg <= shadow_vec;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_output_format <= `ACSP_OUT_FMT_RST;
    end else if (xfer_req) begin
      o_output_format <= shadow_vec[`ACSP_SHADOW_OUT_FMT_IDX*8 +: 8];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_alt_func_en <= 1'b0;
    end else begin
      o_alt_func_en <= tied_high;
    end
  end

endmodule

// ===== acsp_port_monitor.sv
// checker for the serial configuration port, bound to its top module
// assumes the host moves the data line only around its own serial clock
`include "acsp_defines.svh"

module acsp_port_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_sel_n,
  input wire logic i_sdio,
  input wire logic o_sdio,
  input wire logic o_sdio_oe,
  input wire logic o_alt_func_en,
  input wire logic [7:0] o_output_format,
  input wire logic [`ACSP_SHADOW_N*8-1:0] o_active_cfg,
  input wire logic o_shadow_update
);
  ////////////////////////////////////////////////////////////////////////////
  // core cycles for which select has been seen high, saturating
  logic [7:0] hi_cnt;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hi_cnt <= 8'h00;
    end else if (!i_sel_n) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hFF) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_OE_NEEDS_SEL: assert property (
    @(posedge i_core_clk) disable iff (i_rst) i_sel_n |-> !o_sdio_oe)
    else $error("data pin driven while select is high");
  AST_ALT_OFF: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(i_sel_n) && o_alt_func_en |-> ##[1:4] !o_alt_func_en)
    else $error("secondary function still on after select fell");
  AST_ALT_ON: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    hi_cnt >= 8'h1C |-> o_alt_func_en)
    else $error("secondary function off while select tied high");
  AST_ALT_EARLY: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(o_alt_func_en) |-> hi_cnt >= 8'h14)
    else $error("secondary function on too soon");
  AST_UPD_PULSE: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_shadow_update |=> !o_shadow_update)
    else $error("update flag longer than one cycle");
  AST_CFG_ONLY_XFER: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $changed(o_active_cfg) |-> o_shadow_update)
    else $error("active copies changed without a transfer");
  AST_FMT_IS_ACTIVE: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_output_format == o_active_cfg[39:32])
    else $error("format output differs from its active copy");
  AST_OE_BYTE: assert property (
    @(posedge i_sclk) disable iff (i_rst)
    $rose(o_sdio_oe) |-> o_sdio_oe[*8])
    else $error("readback drive shorter than one byte");
endmodule

bind acsp_port acsp_port_monitor mon_u (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sclk(i_sclk),
  .i_sel_n(i_sel_n), .i_sdio(i_sdio), .o_sdio(o_sdio),
  .o_sdio_oe(o_sdio_oe), .o_alt_func_en(o_alt_func_en),
  .o_output_format(o_output_format), .o_active_cfg(o_active_cfg),
  .o_shadow_update(o_shadow_update)
);

// ===== acsp_host_model.sv
// serial master standing in for the host of the configuration port
// assumes the bench resolves the shared data line from both enables
module acsp_host_model (
  input wire logic i_core_clk,
  input wire logic i_sdio,
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_sdio,
  output logic o_sdio_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lsb_first = 1'b0;

  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_sdio = 1'b0;
    o_sdio_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // the serial clock only runs inside frames
  task automatic start();
    @(posedge i_core_clk);
    #2 o_sel_n = 1'b0;
    #100;
  endtask

  // select stays low a while so the core side sees every frame
  task automatic stop();
    #400 o_sel_n = 1'b1;
    o_sdio_oe = 1'b0;
  endtask

  task automatic put_bit(input logic b);
    o_sdio_oe = 1'b1;
    o_sdio = b;
    #3 o_sclk = 1'b1;
    #3 o_sclk = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    o_sdio_oe = 1'b0;
    #3 b = i_sdio;
    o_sclk = 1'b1;
    #3 o_sclk = 1'b0;
  endtask

  task automatic instr(input logic rd, input logic [1:0] w,
                       input logic [7:0] a);
    logic [15:0] v;
    v = {rd, w, 5'h00, a};
    for (int i = 15; i >= 0; i--) put_bit(v[i]);
  endtask

  // only mapped addresses and zeroed spare bits are ever written
  task automatic put_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) put_bit(lsb_first ? d[i] : d[7-i]);
  endtask

  task automatic get_byte(output logic [7:0] d);
    logic b;
    for (int i = 0; i < 8; i++) begin
      get_bit(b);
      if (lsb_first) d[i] = b;
      else d[7-i] = b;
    end
  endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the serial configuration port
// assumes the host model holds the serial clock still between frames
`include "acsp_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sclk, sel_n, host_sdio, host_oe, dut_sdio, dut_oe, alt, upd;
  logic idle_pat = 1'b0;
  int upd_cnt = 0;
  logic [7:0] fmt;
  logic [`ACSP_SHADOW_N*8-1:0] cfg;
  wire logic sdio_wire;
  int num_errors = 0;
  int compares = 0;

  // a released line shows a changing pattern, never the last value
  assign sdio_wire = dut_oe ? dut_sdio : (host_oe ? host_sdio : idle_pat);

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    idle_pat <= ~idle_pat;
    if (upd) upd_cnt <= upd_cnt + 1;
  end

  acsp_port dut_u (
    .i_core_clk(core_clk), .i_rst(i_rst), .i_sclk(sclk), .i_sel_n(sel_n),
    .i_sdio(sdio_wire), .o_sdio(dut_sdio), .o_sdio_oe(dut_oe),
    .o_alt_func_en(alt), .o_output_format(fmt), .o_active_cfg(cfg),
    .o_shadow_update(upd)
  );

  acsp_host_model host_u (
    .i_core_clk(core_clk), .i_sdio(sdio_wire), .o_sclk(sclk),
    .o_sel_n(sel_n), .o_sdio(host_sdio), .o_sdio_oe(host_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // bytes travel lowest first in d and e
  task automatic wr(input logic [1:0] w, input logic [7:0] a,
                    input logic [31:0] d, input int n);
    host_u.start();
    host_u.instr(1'b0, w, a);
    for (int k = 0; k < n; k++) host_u.put_byte(d[8*k +: 8]);
    host_u.stop();
  endtask

  task automatic rd(input logic [1:0] w, input logic [7:0] a,
                    input logic [31:0] e, input int n);
    logic [7:0] b;
    host_u.start();
    host_u.instr(1'b1, w, a);
    for (int k = 0; k < n; k++) begin
      host_u.get_byte(b);
      check({24'h000000, b}, {24'h000000, e[8*k +: 8]});
    end
    host_u.stop();
  endtask

  // exactly one update pulse is expected per transfer command
  task automatic xfer();
    int n0;
    n0 = upd_cnt;
    wr(2'h0, 8'hFF, 32'h01, 1);
    repeat (6) @(posedge core_clk);
    check(32'(upd_cnt - n0), 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [7:0] b;
    repeat (8) @(posedge core_clk);
    #2 i_rst = 1'b0;
    repeat (30) @(posedge core_clk);
    check(32'(fmt), 32'h01);
    check(cfg[31:0], 32'h0000_0000);
    check(32'(cfg[47:32]), 32'h0000_0001);
    check(32'({alt, dut_oe}), 32'h2);
    wr(2'h0, 8'h14, 32'h00, 1);
    rd(2'h0, 8'h14, 32'h00, 1);
    check(32'(fmt), 32'h01);
    xfer();
    check(32'(fmt), 32'h00);
    rd(2'h0, 8'hFF, 32'h00, 1);
    // three bytes with select paused after the first
    host_u.start();
    host_u.instr(1'b0, 2'h2, 8'h3A);
    host_u.put_byte(8'hA1);
    host_u.stop();
    host_u.start();
    host_u.put_byte(8'hB2);
    host_u.put_byte(8'hC3);
    host_u.stop();
    check(32'(cfg[79:56]), 32'h000000);
    // two single-byte reads under one select
    host_u.start();
    host_u.instr(1'b1, 2'h0, 8'h3A);
    host_u.get_byte(b);
    check(32'(b), 32'hA1);
    host_u.instr(1'b1, 2'h0, 8'h3C);
    host_u.get_byte(b);
    check(32'(b), 32'hC3);
    host_u.stop();
    rd(2'h3, 8'h3A, 32'h00C3B2A1, 4);
    rd(2'h1, 8'h3B, 32'hC3B2, 2);
    xfer();
    check(32'(cfg[79:56]), 32'hC3B2A1);
    wr(2'h0, 8'h01, 32'h5A, 1);
    rd(2'h0, 8'h01, 32'h5A, 1);
    rd(2'h0, 8'h05, 32'h00, 1);
    rd(2'h0, 8'hB0, 32'h00, 1);
    wr(2'h0, 8'h00, 32'h40, 1);
    host_u.lsb_first = 1'b1;
    wr(2'h0, 8'h3A, 32'h35, 1);
    rd(2'h0, 8'h3A, 32'h35, 1);
    xfer();
    check(32'(cfg[63:56]), 32'h35);
    wr(2'h0, 8'h00, 32'h00, 1);
    host_u.lsb_first = 1'b0;
    rd(2'h0, 8'h3B, 32'hB2, 1);
    // a reset in mid-run must bring the defaults back
    @(posedge core_clk);
    #2 i_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #2 i_rst = 1'b0;
    repeat (3) @(posedge core_clk);
    check(32'(fmt), 32'h01);
    check(32'(cfg[79:56]), 32'h000000);
    rd(2'h0, 8'h14, 32'h01, 1);
    repeat (30) @(posedge core_clk);
    check(32'({alt, dut_oe}), 32'h2);
    report_and_stop();
  end
endmodule
